// file: rtl/lpc_pkg.sv
// Summary of operation
// - Start task begins operation; ready event follows once startup time elapses.
// - Upward crossing sets both the rise flag and the any-crossing flag.
// - Downward crossing sets both the fall flag and the any-crossing flag.
// - Hysteresis moves thresholds half the hysteresis voltage above and below reference.
// - Stop task halts operation; no crossing events until the next start.
// - Sample task captures present comparator output into read-only result register.
// - Hysteresis is off after reset; software sets it before enabling.
// - While enabled, registers keep contents and operation continues through system-off.
// - Waking from system-off returns every register to its reset value.
// - A crossing during system-off raises only wake detect, no event flags.
// - Wake detect source is up, down or any crossing per detect config.
// - Input select picks one of eight analog pins as positive input.
// - External reference select picks one of two pins as reference.
// - Selected pins are claimed when the enable register is set.
// - Shortcuts: ready triggers sample or stop, downward event triggers stop.
// - Internal reference comes from a ladder in sixteenths of supply.
// - Further shortcuts let upward or any-crossing events trigger stop.
// - Detect config encodes 0 any, 1 upward only, 2 downward only.
// - Reference select codes 0-6 eighths, 7 external, 8-15 odd sixteenths; reset 4.
// - Ready event follows start after a startup delay of 140 microseconds.
package lpc_pkg;

  localparam longint CLK_HZ        = 20_000_000;
  localparam longint STARTUP_US    = 140;
  localparam logic [11:0] STARTUP_CYCLES =
    12'((STARTUP_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);

  localparam int ADDR_W = 12;

  localparam logic [11:0] OFF_START   = 12'h000;
  localparam logic [11:0] OFF_STOP    = 12'h004;
  localparam logic [11:0] OFF_SAMPLE  = 12'h008;
  localparam logic [11:0] OFF_READY   = 12'h100;
  localparam logic [11:0] OFF_FALL    = 12'h104;
  localparam logic [11:0] OFF_RISE    = 12'h108;
  localparam logic [11:0] OFF_CROSS   = 12'h10c;
  localparam logic [11:0] OFF_LINKS   = 12'h200;
  localparam logic [11:0] OFF_IEN_SET = 12'h304;
  localparam logic [11:0] OFF_IEN_CLR = 12'h308;
  localparam logic [11:0] OFF_RESULT  = 12'h400;
  localparam logic [11:0] OFF_ENABLE  = 12'h500;
  localparam logic [11:0] OFF_INSEL   = 12'h504;
  localparam logic [11:0] OFF_THRESHOLD_CHOICE  = 12'h508;
  localparam logic [11:0] OFF_EXTREF  = 12'h50c;
  localparam logic [11:0] OFF_DETECT  = 12'h520;
  localparam logic [11:0] OFF_HYSTERESIS_ON    = 12'h538;

  localparam logic [3:0] RST_THRESHOLD_CHOICE = 4'h4;
  localparam logic [3:0] REF_EXTERNAL = 4'h7;

  // Auto task link bit positions
  localparam int LNK_READY_SAMPLE = 0;
  localparam int LNK_READY_STOP   = 1;
  localparam int LNK_DOWN_STOP    = 2;
  localparam int LNK_UP_STOP      = 3;
  localparam int LNK_CROSS_STOP   = 4;

  // Interrupt enable / flag bit positions
  localparam int EV_READY = 0;
  localparam int EV_FALL  = 1;
  localparam int EV_RISE  = 2;
  localparam int EV_CROSS = 3;

  localparam logic [1:0] DET_ANY  = 2'h0;
  localparam logic [1:0] DET_UP   = 2'h1;
  localparam logic [1:0] DET_DOWN = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_RUN  = 2'b11
  } lpc_state_e;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
    logic [31:0] data;
  } lpc_wr_s;

  typedef struct packed {
    logic       active;
    logic       claim;
    logic       hysteresis_on;
    logic [3:0] threshold_choice;
    logic       useExtRef;
    logic       extRefPin;
    logic [2:0] inSel;
  } lpc_analog_s;

endpackage

// file: rtl/lpc_sync.sv
`timescale 1ns/10ps
module lpc_sync import lpc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // System clock
  input  wire logic             rst,   // Synchronous reset
  input  wire logic [WIDTH-1:0] async, // Level from another domain
  output logic      [WIDTH-1:0] sync   // Two-stage synchronised level
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      sync   <= '0;
    end else begin
      stage1 <= async;
      sync   <= stage1;
    end
  end

endmodule

// file: rtl/lpc_axil_slave.sv
`timescale 1ns/10ps
module lpc_axil_slave import lpc_pkg::*; (
  input  wire logic              clk,     // System clock
  input  wire logic              rst,     // Synchronous reset
  input  wire logic [ADDR_W-1:0] awaddr,  // Write address
  input  wire logic              awvalid, // Write address valid
  output logic                   awready, // Write address ready
  input  wire logic [31:0]       wdata,   // Write data
  input  wire logic [3:0]        wstrb,   // Write byte strobes
  input  wire logic              wvalid,  // Write data valid
  output logic                   wready,  // Write data ready
  output logic [1:0]             bresp,   // Write response
  output logic                   bvalid,  // Write response valid
  input  wire logic              bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,  // Read address
  input  wire logic              arvalid, // Read address valid
  output logic                   arready, // Read address ready
  output logic [31:0]            rdata,   // Read data
  output logic [1:0]             rresp,   // Read response
  output logic                   rvalid,  // Read data valid
  input  wire logic              rready,  // Read data ready
  output lpc_wr_s                wr,      // Register write strobe
  input  wire logic              wrErr,   // Write address unmapped
  output logic [ADDR_W-1:0]      rdAddr,  // Read address to decoder
  input  wire logic [31:0]       rdData,  // Decoded read data
  input  wire logic              rdErr    // Read address unmapped
);

  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] heldAddr;
  logic [31:0]       heldData;
  logic              heldStrb;

  wire awTake      = awvalid & awready;
  wire wTake       = wvalid & wready;
  wire arTake      = arvalid & arready;
  wire haveAw      = awHeld | awTake;
  wire haveW       = wHeld | wTake;
  wire doWrite     = haveAw & haveW;
  wire next_awHeld = haveAw & ~doWrite;
  wire next_wHeld  = haveW & ~doWrite;
  wire next_bvalid = doWrite | (bvalid & ~bready);
  wire next_rvalid = arTake | (rvalid & ~rready);
  wire strbLow     = wHeld ? heldStrb : wstrb[0];

  // Byte lane 0 carries every field, other lanes are ignored
  assign wr.en   = doWrite & strbLow;
  assign wr.addr = awHeld ? heldAddr : awaddr;
  assign wr.data = wHeld ? heldData : wdata;
  assign rdAddr  = araddr;

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld   <= 1'b0;
      wHeld    <= 1'b0;
      heldAddr <= '0;
      heldData <= 32'h0;
      heldStrb <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rdata    <= 32'h0;
      rresp    <= RESP_OKAY;
    end else begin
      awHeld  <= next_awHeld;
      wHeld   <= next_wHeld;
      awready <= ~next_awHeld & ~next_bvalid;
      wready  <= ~next_wHeld & ~next_bvalid;
      bvalid  <= next_bvalid;
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (awTake) begin
        heldAddr <= awaddr;
      end
      if (wTake) begin
        heldData <= wdata;
        heldStrb <= wstrb[0];
      end
      if (doWrite) begin
        bresp <= wrErr ? RESP_SLVERR : RESP_OKAY;
      end
      if (arTake) begin
        rdata <= rdErr ? 32'h0 : rdData;
        rresp <= rdErr ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

endmodule

// file: rtl/lpc_comparator.sv
`timescale 1ns/10ps
module lpc_comparator import lpc_pkg::*; (
  input  wire logic              clk,           // 20 MHz peripheral clock
  input  wire logic              rst,           // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic              s_axi_awvalid, // Write address valid
  output logic                   s_axi_awready, // Write address ready
  input  wire logic [31:0]       s_axi_wdata,   // Write data
  input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
  input  wire logic              s_axi_wvalid,  // Write data valid
  output logic                   s_axi_wready,  // Write data ready
  output logic [1:0]             s_axi_bresp,   // Write response
  output logic                   s_axi_bvalid,  // Write response valid
  input  wire logic              s_axi_bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic              s_axi_arvalid, // Read address valid
  output logic                   s_axi_arready, // Read address ready
  output logic [31:0]            s_axi_rdata,   // Read data
  output logic [1:0]             s_axi_rresp,   // Read response
  output logic                   s_axi_rvalid,  // Read data valid
  input  wire logic              s_axi_rready,  // Read data ready
  input  wire logic              compOut,       // Analog core decision, asynchronous
  input  wire logic              sysOff,        // System-off mode level
  input  wire logic              wakeFromOff,   // Wake from system-off pulse
  output lpc_analog_s            analogCfg,     // Settings to analog core
  output logic                   wakeDetect,    // Wake request to power control
  output logic                   irq            // Interrupt request
);

  lpc_wr_s           wr;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0]       rdData;
  logic              rdErr;
  logic              wrErr;
  logic              compSync;

  lpc_axil_slave u_bus (
    .clk     (clk),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr      (wr),
    .wrErr   (wrErr),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .rdErr   (rdErr)
  );

  lpc_sync #(.WIDTH(1)) u_compSync (
    .clk   (clk),
    .rst   (rst),
    .async (compOut),
    .sync  (compSync)
  );

  // Register state
  lpc_state_e  state;
  logic [11:0] warmCnt;
  logic        prevComp;
  logic        readyFlag;
  logic        fallFlag;
  logic        riseFlag;
  logic        crossFlag;
  logic [4:0]  links;
  logic [3:0]  irqEn;
  logic        result;
  logic        enable;
  logic [2:0]  inSel;
  logic [3:0]  threshold_choice;
  logic        extRef;
  logic [1:0]  detectCfg;
  logic        hysteresis_on;

  // Wake from system-off restores every reset value
  wire regReset = rst | wakeFromOff;

  // Write decode
  wire wrStart  = wr.en & (wr.addr == OFF_START);
  wire wrStop   = wr.en & (wr.addr == OFF_STOP);
  wire wrSample = wr.en & (wr.addr == OFF_SAMPLE);
  wire wrReady  = wr.en & (wr.addr == OFF_READY);
  wire wrFall   = wr.en & (wr.addr == OFF_FALL);
  wire wrRise   = wr.en & (wr.addr == OFF_RISE);
  wire wrCross  = wr.en & (wr.addr == OFF_CROSS);
  wire wrLinks  = wr.en & (wr.addr == OFF_LINKS);
  wire wrIenSet = wr.en & (wr.addr == OFF_IEN_SET);
  wire wrIenClr = wr.en & (wr.addr == OFF_IEN_CLR);
  wire wrEnable = wr.en & (wr.addr == OFF_ENABLE);
  wire wrInSel  = wr.en & (wr.addr == OFF_INSEL);
  wire wrRefSel = wr.en & (wr.addr == OFF_THRESHOLD_CHOICE);
  wire wrExtRef = wr.en & (wr.addr == OFF_EXTREF);
  wire wrDetect = wr.en & (wr.addr == OFF_DETECT);
  wire wrHyst   = wr.en & (wr.addr == OFF_HYSTERESIS_ON);

  // Tasks are one-cycle strobes and hold no storage
  wire taskStart  = wrStart & wr.data[0];
  wire taskStop   = wrStop & wr.data[0];
  wire taskSample = wrSample & wr.data[0];

  // Read decode
  wire hitStart  = (rdAddr == OFF_START);
  wire hitStop   = (rdAddr == OFF_STOP);
  wire hitSample = (rdAddr == OFF_SAMPLE);
  wire hitReady  = (rdAddr == OFF_READY);
  wire hitFall   = (rdAddr == OFF_FALL);
  wire hitRise   = (rdAddr == OFF_RISE);
  wire hitCross  = (rdAddr == OFF_CROSS);
  wire hitLinks  = (rdAddr == OFF_LINKS);
  wire hitIenSet = (rdAddr == OFF_IEN_SET);
  wire hitIenClr = (rdAddr == OFF_IEN_CLR);
  wire hitResult = (rdAddr == OFF_RESULT);
  wire hitEnable = (rdAddr == OFF_ENABLE);
  wire hitInSel  = (rdAddr == OFF_INSEL);
  wire hitRefSel = (rdAddr == OFF_THRESHOLD_CHOICE);
  wire hitExtRef = (rdAddr == OFF_EXTREF);
  wire hitDetect = (rdAddr == OFF_DETECT);
  wire hitHyst   = (rdAddr == OFF_HYSTERESIS_ON);

  wire rdHit = hitStart | hitStop | hitSample | hitReady | hitFall | hitRise
             | hitCross | hitLinks | hitIenSet | hitIenClr | hitResult
             | hitEnable | hitInSel | hitRefSel | hitExtRef | hitDetect | hitHyst;

  wire wrHit = wrStart | wrStop | wrSample | wrReady | wrFall | wrRise | wrCross
             | wrLinks | wrIenSet | wrIenClr | wrEnable | wrInSel | wrRefSel
             | wrExtRef | wrDetect | wrHyst;

  assign rdErr = ~rdHit;
  // Result register is read-only; a write there is ignored but answered OKAY
  assign wrErr = wr.en & ~wrHit & (wr.addr != OFF_RESULT);

  // Task offsets read back as zero
  assign rdData = ({32{hitReady}}  & {31'h0, readyFlag})
                | ({32{hitFall}}   & {31'h0, fallFlag})
                | ({32{hitRise}}   & {31'h0, riseFlag})
                | ({32{hitCross}}  & {31'h0, crossFlag})
                | ({32{hitLinks}}  & {27'h0, links})
                | ({32{hitIenSet | hitIenClr}} & {28'h0, irqEn})
                | ({32{hitResult}} & {31'h0, result})
                | ({32{hitEnable}} & {31'h0, enable})
                | ({32{hitInSel}}  & {29'h0, inSel})
                | ({32{hitRefSel}} & {28'h0, threshold_choice})
                | ({32{hitExtRef}} & {31'h0, extRef})
                | ({32{hitDetect}} & {30'h0, detectCfg})
                | ({32{hitHyst}}   & {31'h0, hysteresis_on});

  // Sequencer
  wire isRun     = (state == ST_RUN);
  wire isWarm    = (state == ST_WARM);
  wire warmDone  = isWarm & (warmCnt == STARTUP_CYCLES - 12'h1);
  wire readyEvt  = warmDone & ~sysOff;

  // Crossings are only seen once running; stop halts them
  wire upCross   = isRun & compSync & ~prevComp;
  wire downCross = isRun & ~compSync & prevComp;

  // In system-off a crossing feeds wake detect only
  wire evtUp     = upCross & ~sysOff;
  wire evtDown   = downCross & ~sysOff;
  wire evtAny    = evtUp | evtDown;

  wire detSel    = (detectCfg == DET_ANY)  ? (upCross | downCross)
                 : (detectCfg == DET_UP)   ? upCross
                 : (detectCfg == DET_DOWN) ? downCross
                 : 1'b0;
  wire wakeHit   = sysOff & detSel;

  wire linkSample = readyEvt & links[LNK_READY_SAMPLE];
  wire linkStop   = (readyEvt & links[LNK_READY_STOP])
                  | (evtDown & links[LNK_DOWN_STOP])
                  | (evtUp & links[LNK_UP_STOP])
                  | (evtAny & links[LNK_CROSS_STOP]);

  wire doStop    = taskStop | linkStop;
  wire doStart   = taskStart & enable;
  wire doSample  = taskSample | linkSample;

  // Stop or a cleared enable overrides every other move
  lpc_state_e next_state;
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_state = doStart ? ST_WARM : ST_IDLE;
      end
      ST_WARM: begin
        if (doStart | ~warmDone) begin
          next_state = ST_WARM;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = doStart ? ST_WARM : ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (~enable | doStop) begin
      next_state = ST_IDLE;
    end
  end

  // Hardware set wins over a software clear in the same cycle
  wire next_readyFlag = readyEvt | (wrReady ? wr.data[0] : readyFlag);
  wire next_fallFlag  = evtDown | (wrFall ? wr.data[0] : fallFlag);
  wire next_riseFlag  = evtUp | (wrRise ? wr.data[0] : riseFlag);
  wire next_crossFlag = evtAny | (wrCross ? wr.data[0] : crossFlag);

  wire [3:0] next_irqEn = wrIenSet ? (irqEn | wr.data[3:0])
                        : wrIenClr ? (irqEn & ~wr.data[3:0])
                        : irqEn;

  always_ff @(posedge clk) begin
    if (regReset) begin
      state   <= ST_IDLE;
      warmCnt <= 12'h0;
    end else begin
      state   <= next_state;
      warmCnt <= (isWarm && next_state == ST_WARM && !doStart) ? warmCnt + 12'h1 : 12'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (regReset) begin
      prevComp <= 1'b0;
      result   <= 1'b0;
    end else begin
      prevComp <= compSync;
      if (doSample) begin
        result <= compSync;
      end
    end
  end

  // Reset, a wake or a software write clears these; system-off alone does not
  always_ff @(posedge clk) begin
    if (regReset) begin
      readyFlag <= 1'b0;
      fallFlag  <= 1'b0;
      riseFlag  <= 1'b0;
      crossFlag <= 1'b0;
      irqEn     <= 4'h0;
    end else begin
      readyFlag <= next_readyFlag;
      fallFlag  <= next_fallFlag;
      riseFlag  <= next_riseFlag;
      crossFlag <= next_crossFlag;
      irqEn     <= next_irqEn;
    end
  end

  // Request follows the flags on the edge that sets them
  always_ff @(posedge clk) begin
    if (regReset) begin
      irq <= 1'b0;
    end else begin
      irq <= |({next_crossFlag, next_riseFlag, next_fallFlag, next_readyFlag}
               & next_irqEn);
    end
  end

  always_ff @(posedge clk) begin
    if (regReset) begin
      links     <= 5'h00;
      enable    <= 1'b0;
      inSel     <= 3'h0;
      threshold_choice    <= RST_THRESHOLD_CHOICE;
      extRef    <= 1'b0;
      detectCfg <= DET_ANY;
      hysteresis_on      <= 1'b0;
    end else begin
      if (wrLinks) begin
        links <= wr.data[4:0];
      end
      if (wrEnable) begin
        enable <= wr.data[0];
      end
      if (wrInSel) begin
        inSel <= wr.data[2:0];
      end
      if (wrRefSel) begin
        threshold_choice <= wr.data[3:0];
      end
      if (wrExtRef) begin
        extRef <= wr.data[0];
      end
      if (wrDetect) begin
        detectCfg <= wr.data[1:0];
      end
      if (wrHyst) begin
        hysteresis_on <= wr.data[0];
      end
    end
  end

  // Held until the wake clears it
  always_ff @(posedge clk) begin
    if (regReset) begin
      wakeDetect <= 1'b0;
    end else if (wakeHit) begin
      wakeDetect <= 1'b1;
    end
  end

  // Analog core runs whenever started, whether system-on or system-off
  always_ff @(posedge clk) begin
    if (regReset) begin
      analogCfg.active    <= 1'b0;
      analogCfg.claim     <= 1'b0;
      analogCfg.hysteresis_on      <= 1'b0;
      analogCfg.threshold_choice    <= RST_THRESHOLD_CHOICE;
      analogCfg.useExtRef <= 1'b0;
      analogCfg.extRefPin <= 1'b0;
      analogCfg.inSel     <= 3'h0;
    end else begin
      analogCfg.active    <= (next_state != ST_IDLE);
      analogCfg.claim     <= enable;
      analogCfg.hysteresis_on      <= hysteresis_on;
      analogCfg.threshold_choice    <= threshold_choice;
      analogCfg.useExtRef <= (threshold_choice == REF_EXTERNAL);
      analogCfg.extRefPin <= extRef;
      analogCfg.inSel     <= inSel;
    end
  end

endmodule

// file: tb/lpc_comparator_assertions.sv
`timescale 1ns/10ps
module lpc_comparator_assertions import lpc_pkg::*; (
  input wire logic        clk,          // Clock
  input wire logic        rst,          // Reset
  input wire logic        s_axi_bvalid, // Write response valid
  input wire logic        sysOff,       // System-off level
  input wire logic        wakeFromOff,  // Wake reset
  input wire lpc_analog_s analogCfg,    // Analog settings
  input wire logic        wakeDetect,   // Wake request
  input wire logic        irq           // Interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_start; $rose(analogCfg.active) |-> $rose(s_axi_bvalid); endproperty
  a_start: assert property (p_start) else $error("start without write");
  property p_claim; $rose(analogCfg.claim) |-> $past(s_axi_bvalid); endproperty
  a_claim: assert property (p_claim) else $error("claim without write");
  property p_wake_src; $rose(wakeDetect) |-> $past(sysOff) && $past(analogCfg.active); endproperty
  a_wake_src: assert property (p_wake_src) else $error("wake outside off");
  property p_wake_hold; wakeDetect && !wakeFromOff |=> wakeDetect; endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
  property p_off_quiet; sysOff && $past(sysOff) && $rose(irq) |-> $rose(s_axi_bvalid); endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("event in off mode");
  property p_cfg_hold; $changed(analogCfg.threshold_choice) || $changed(analogCfg.hysteresis_on)
    |-> $past(s_axi_bvalid) || $past(wakeFromOff); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("setting lost");
  property p_wake_rst; wakeFromOff |=> !wakeDetect && !irq && !analogCfg.active; endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake reset missed");
  property p_ext_ref; analogCfg.useExtRef == (analogCfg.threshold_choice == REF_EXTERNAL); endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("reference pick wrong");
endmodule
bind lpc_comparator lpc_comparator_assertions u_chk (
  .clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid), .sysOff(sysOff),
  .wakeFromOff(wakeFromOff), .analogCfg(analogCfg), .wakeDetect(wakeDetect), .irq(irq)
);

// file: tb/lpc_analog_model.sv
`timescale 1ns/10ps
module lpc_analog_model import lpc_pkg::*; (
  input wire logic        clk,     // Clock
  input wire lpc_analog_s cfg,     // Settings from the block
  input wire logic [7:0]  pinHigh, // Pins above threshold
  output logic            compOut  // Decision
);
  initial compOut = 1'b0;
  // Unpowered core gives no stable level
  always @(posedge clk) begin
    if (cfg.active)
      compOut <= pinHigh[cfg.inSel];
    else
      compOut <= ~compOut;
  end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top import lpc_pkg::*; ;
  logic        clk = 1'b0, rst = 1'b1, sysOff = 1'b0, wakeFromOff = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [7:0]  pinHigh = 8'h00;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bres, rres;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        compOut, wakeDetect, irq;
  lpc_analog_s analogCfg;
  int          n_errors = 0, cmp_count = 0, cyc = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  lpc_comparator dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .compOut, .sysOff, .wakeFromOff, .analogCfg, .wakeDetect, .irq
  );
  lpc_analog_model u_core (.clk, .cfg(analogCfg), .pinHigh, .compOut);

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    bres = s_axi_bresp;
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rres = s_axi_rresp;
    chk(nm, rdat, e);
  endtask

  // Selected pin moves, all others move the opposite way
  task automatic pin(input logic v);
    pinHigh <= v ? 8'h08 : 8'hf7;
    repeat (8) @(posedge clk);
  endtask

  task automatic start_run(input logic [3:0] r);
    int n;
    for (int k = 0; k < 4; k++) wr(OFF_READY + 12'(4 * k), 32'h0);
    wr(OFF_IEN_SET, 32'h1);
    wr(OFF_INSEL, 32'h3);
    wr(OFF_THRESHOLD_CHOICE, {28'h0, r});
    wr(OFF_EXTREF, 32'h1);
    wr(OFF_HYSTERESIS_ON, 32'h1);
    wr(OFF_ENABLE, 32'h1);
    wr(OFF_START, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("startup", n, STARTUP_CYCLES);
    chk("cfg", {analogCfg.claim, analogCfg.hysteresis_on, analogCfg.threshold_choice, analogCfg.inSel,
                analogCfg.useExtRef, analogCfg.extRefPin},
        {2'b11, r, 3'h3, r == REF_EXTERNAL, 1'b1});
    wr(OFF_IEN_CLR, 32'h1);
    chk("irq off", irq, 1'b0);
  endtask

  task automatic t_regs;
    rc(OFF_THRESHOLD_CHOICE, 32'h4, "threshold_choice");
    rc(OFF_HYSTERESIS_ON, 32'h0, "hysteresis_on");
    wr(OFF_START, 32'h1);
    chk("idle", analogCfg.active, 1'b0);
    rc(12'h010, 32'h0, "unmapped");
    chk("rresp", rres, RESP_SLVERR);
    wr(12'h014, 32'h1);
    chk("bresp", bres, RESP_SLVERR);
    $display("t_regs done");
  endtask

  task automatic t_cross;
    pin(1'b0);
    start_run(4'h9);
    pin(1'b1);
    rc(OFF_RISE, 32'h1, "rise");
    rc(OFF_CROSS, 32'h1, "cross up");
    rc(OFF_FALL, 32'h0, "no fall");
    wr(OFF_CROSS, 32'h0);
    rc(OFF_CROSS, 32'h0, "cleared");
    wr(OFF_SAMPLE, 32'h1);
    rc(OFF_RESULT, 32'h1, "result");
    rc(OFF_SAMPLE, 32'h0, "task read");
    pin(1'b0);
    rc(OFF_FALL, 32'h1, "fall");
    rc(OFF_CROSS, 32'h1, "cross down");
    wr(OFF_STOP, 32'h1);
    wr(OFF_CROSS, 32'h0);
    pin(1'b1);
    rc(OFF_CROSS, 32'h0, "stopped");
    $display("t_cross done");
  endtask

  task automatic t_links;
    wr(OFF_LINKS, 32'h3);
    start_run(4'h4);
    chk("ready stop", analogCfg.active, 1'b0);
    rc(OFF_RESULT, 32'h1, "auto sample");
    for (int i = 2; i < 5; i++) begin
      pin(i == 2);
      wr(OFF_LINKS, 32'h1 << i);
      start_run(4'h4);
      pin(i != 2);
      chk("link stop", analogCfg.active, 1'b0);
    end
    $display("t_links done");
  endtask

  task automatic t_off;
    wr(OFF_LINKS, 32'h0);
    for (int d = 0; d < 3; d++) begin
      pin(d != 2);
      start_run(REF_EXTERNAL);
      wr(OFF_DETECT, 32'(d));
      sysOff <= 1'b1;
      pin(d == 2);
      chk("wake first", wakeDetect, d == 0);
      pin(d != 2);
      chk("wake", wakeDetect, 1'b1);
      rc(OFF_RISE, 32'h0, "no rise");
      rc(OFF_FALL, 32'h0, "no fall");
      rc(OFF_ENABLE, 32'h1, "kept");
      wr(OFF_IEN_SET, 32'h1);
      chk("irq on", irq, 1'b1);
      wakeFromOff <= 1'b1;
      @(posedge clk);
      wakeFromOff <= 1'b0;
      sysOff <= 1'b0;
      @(posedge clk);
      chk("wake clr", wakeDetect, 1'b0);
      rc(OFF_ENABLE, 32'h0, "enable rst");
      rc(OFF_THRESHOLD_CHOICE, 32'h4, "threshold_choice rst");
    end
    $display("t_off done");
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_cross();
    t_links();
    t_off();
    give_verdict();
  end
endmodule
